/* File: core/dram_host_ctrl.sv */
// Notes on behaviour
// - Address goes out on six lines: row half first, then column half.
// - Every row is refreshed at least once per refresh period.
// - Eight refresh cycles follow power-up before any access is served.
// - Row strobe is never held low beyond its maximum pulse width.
`timescale 1ns/1ps
`default_nettype none
`include "dram_host_map.svh"

module dram_host_ctrl #(
  parameter int REFRESH_ROW_CYCLES = `REFRESH_ROW_CYC,
  parameter int INIT_REFRESHES = `INIT_REFRESHES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  // user side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_rmw,
  input wire logic [11:0] req_addr,
  input wire logic req_wdata,
  output logic rsp_valid,
  output logic rsp_rdata,
  output logic init_done,
  // memory pins
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic cs_n,
  output logic [5:0] muxed_address_lines,
  output logic din,
  input wire logic dout
);

  dram_host_pkg::ctrl_regs_t q, d;
  logic ref_due;
  logic take;
  logic page_ok;

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] row_of(input logic [11:0] a);
    row_of = a[`ROW_MSB:`ROW_LSB];
  endfunction

  function automatic logic [5:0] col_of(input logic [11:0] a);
    col_of = a[`COL_MSB:`COL_LSB];
  endfunction

  // ----------------------------------------------------------------
  // refresh pacing
  // ----------------------------------------------------------------
  refresh_timer #(
    .INTERVAL(REFRESH_ROW_CYCLES)
  ) u_refresh_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .ack(q.ref_ack),
    .due(ref_due)
  );

  // ----------------------------------------------------------------
  // request acceptance
  // ----------------------------------------------------------------
  // page continues only with slack left under the row pulse limit
  assign page_ok = (q.ras_cnt < 8'(`RAS_MAX_CYC - `PAGE_SLACK_CYC));
  assign init_done = (q.init_cnt == 4'(INIT_REFRESHES));
  always_comb begin
    req_ready = 1'b0;
    if (q.state == dram_host_pkg::S_IDLE) begin
      req_ready = init_done && !ref_due;
    end else if (q.state == dram_host_pkg::S_CEND) begin
      req_ready = !ref_due && page_ok && (row_of(req_addr) == row_of(q.addr));
    end
  end
  assign take = req_valid && req_ready;

  // ----------------------------------------------------------------
  // strobe sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    d.ref_ack = 1'b0;
    // row time is tracked to keep page bursts bounded
    if (!q.ras_n && q.ras_cnt != 8'hFF) begin
      d.ras_cnt = q.ras_cnt + 8'h01;
    end
    case (q.state)
      dram_host_pkg::S_IDLE: begin
        if (take) begin
          d.addr = req_addr;
          d.write = req_write || req_rmw;
          d.rmw = req_rmw;
          d.wdata = req_wdata;
          d.refresh = 1'b0;
          d.pins = row_of(req_addr);
          d.cs_n = 1'b0;
          d.state = dram_host_pkg::S_ROW;
        end else if (ref_due || !init_done) begin
          d.refresh = 1'b1;
          d.pins = q.ref_row;
          d.state = dram_host_pkg::S_ROW;
        end
      end
      dram_host_pkg::S_ROW: begin
        // address settled a cycle before the fall
        d.ras_n = 1'b0;
        d.ras_cnt = 8'h00;
        d.cnt = 4'h0;
        d.state = q.refresh ? dram_host_pkg::S_REF : dram_host_pkg::S_RAS;
      end
      dram_host_pkg::S_REF: begin
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(`RAS_MIN_CYC - 1)) begin
          d.ras_n = 1'b1;
          d.ref_row = q.ref_row + 6'h01;
          d.ref_ack = 1'b1;
          if (!init_done) begin
            d.init_cnt = q.init_cnt + 4'h1;
          end
          d.cnt = 4'h0;
          d.state = dram_host_pkg::S_PRE;
        end
      end
      dram_host_pkg::S_RAS: begin
        // row hold met by one cycle; column half goes out now
        d.pins = col_of(q.addr);
        d.we_n = !(q.write && !q.rmw);
        d.din = q.wdata;
        d.state = dram_host_pkg::S_COL;
      end
      dram_host_pkg::S_COL: begin
        // late column fall trades row access for column access timing
        d.cas_n = 1'b0;
        d.cnt = 4'h0;
        d.state = dram_host_pkg::S_CAS;
      end
      dram_host_pkg::S_CAS: begin
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(`CAS_HOLD_CYC - 1)) begin
          d.cnt = 4'h0;
          if (q.rmw) begin
            d.rdata = dout;
            d.we_n = 1'b0;
            d.state = dram_host_pkg::S_WE;
          end else begin
            if (!q.write) begin
              d.rdata = dout;
            end
            d.cas_n = 1'b1;
            d.we_n = 1'b1;
            d.rsp_valid = 1'b1;
            d.state = dram_host_pkg::S_CEND;
          end
        end
      end
      dram_host_pkg::S_WE: begin
        // write strobe lead ahead of both strobes rising
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(`WE_HOLD_CYC - 1)) begin
          d.cas_n = 1'b1;
          d.we_n = 1'b1;
          d.rsp_valid = 1'b1;
          d.state = dram_host_pkg::S_CEND;
        end
      end
      dram_host_pkg::S_CEND: begin
        // column precharge: one cycle here plus S_COL
        if (take) begin
          d.addr = req_addr;
          d.write = req_write || req_rmw;
          d.rmw = req_rmw;
          d.wdata = req_wdata;
          d.pins = col_of(req_addr);
          d.we_n = !(req_write && !req_rmw);
          d.din = req_wdata;
          d.state = dram_host_pkg::S_COL;
        end else begin
          d.ras_n = 1'b1;
          d.cs_n = 1'b1;
          d.cnt = 4'h0;
          d.state = dram_host_pkg::S_PRE;
        end
      end
      dram_host_pkg::S_PRE: begin
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(`RP_CYC - 1)) begin
          d.cnt = 4'h0;
          d.state = dram_host_pkg::S_IDLE;
        end
      end
      default: begin
        d.state = dram_host_pkg::S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      q <= '0;
      q.state <= dram_host_pkg::S_IDLE;
      q.ras_n <= 1'b1;
      q.cas_n <= 1'b1;
      q.we_n <= 1'b1;
      q.cs_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign rsp_valid = q.rsp_valid;
  assign rsp_rdata = q.rdata;
  assign ras_n = q.ras_n;
  assign cas_n = q.cas_n;
  assign we_n = q.we_n;
  assign cs_n = q.cs_n;
  assign muxed_address_lines = q.pins;
  assign din = q.din;

endmodule
`default_nettype wire

/* File: shared/dram_host_map.svh */
`ifndef DRAM_HOST_MAP_SVH
`define DRAM_HOST_MAP_SVH

// ----------------------------------------------------------------
// clock and rounding helpers
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
// least times round up, longest times round down
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MAX(ns) ((ns) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// strobe timing of the memory, in ns
// ----------------------------------------------------------------
`define ROW_PRECHARGE_NS 120
`define ROW_PULSE_WIDTH_MIN_NS 200
`define ROW_PULSE_WIDTH_MAX_NS 5000
`define COL_ACCESS_TIME_NS 135
`define COL_PULSE_MIN_NS 135
`define ROW_STROBE_HOLD_NS 135
`define WRITE_PULSE_NS 55
`define WRITE_LEAD_NS 70
`define REFRESH_INTERVAL_NS 2000000

// ----------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------
`define RP_CYC `CYC_MIN(`ROW_PRECHARGE_NS)
`define RAS_MIN_CYC `CYC_MIN(`ROW_PULSE_WIDTH_MIN_NS)
`define RAS_MAX_CYC `CYC_MAX(`ROW_PULSE_WIDTH_MAX_NS)
`define CAS_HOLD_CYC `CYC_MIN(`COL_ACCESS_TIME_NS)
`define WE_HOLD_CYC `CYC_MIN(`WRITE_LEAD_NS)
`define PAGE_SLACK_CYC 16
`define ROW_COUNT 64
`define REFRESH_ROW_CYC (`CYC_MAX(`REFRESH_INTERVAL_NS) / `ROW_COUNT)
`define INIT_REFRESHES 8

// ----------------------------------------------------------------
// address split
// ----------------------------------------------------------------
`define ROW_MSB 11
`define ROW_LSB 6
`define COL_MSB 5
`define COL_LSB 0

`endif

/* File: shared/dram_host_pkg.sv */
`default_nettype none
package dram_host_pkg;

  typedef enum {
    S_IDLE,
    S_ROW,
    S_RAS,
    S_COL,
    S_CAS,
    S_WE,
    S_CEND,
    S_REF,
    S_PRE
  } ctrl_state_t;

  typedef struct packed {
    ctrl_state_t state;
    logic [3:0] cnt;
    logic [7:0] ras_cnt;
    logic [3:0] init_cnt;
    logic [5:0] ref_row;
    logic refresh;
    logic [11:0] addr;
    logic write;
    logic rmw;
    logic wdata;
    logic rdata;
    logic rsp_valid;
    logic ref_ack;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cs_n;
    logic [5:0] pins;
    logic din;
  } ctrl_regs_t;

endpackage
`default_nettype wire

/* File: core/refresh_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dram_host_map.svh"

module refresh_timer #(
  parameter int INTERVAL = `REFRESH_ROW_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ack,
  output logic due
);

  localparam int W = $clog2(INTERVAL + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic due;
  } timer_regs_t;

  timer_regs_t q, d;

  // ----------------------------------------------------------------
  // one row owed per interval
  // ----------------------------------------------------------------
  // set wins over ack so a tick in the ack cycle is not lost
  always_comb begin
    d = q;
    if (ack) begin
      d.due = 1'b0;
    end
    if (q.cnt == W'(INTERVAL - 1)) begin
      d.cnt = '0;
      d.due = 1'b1;
    end else begin
      d.cnt = q.cnt + W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign due = q.due;

endmodule
`default_nettype wire

/* File: testbench/dram_host_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dram_host_ctrl_monitor #(
  parameter int REFRESH_ROW_CYCLES = 781,
  parameter int INIT_REFRESHES = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic init_done,
  input wire logic rsp_valid,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cs_n,
  input wire logic [5:0] muxed_address_lines,
  input wire logic din
);
  // ------
  // strobe history
  // ------
  localparam int RAS_MAX = 125;
  int ras_low_q;
  int since_ref_q;
  int ref_cnt_q;
  logic ras_q;
  logic ref_fall;
  // refresh is a row fall with the chip deselected
  assign ref_fall = !ras_n && ras_q && cs_n;
  // low time, refresh spacing, refreshes since reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ras_q <= 1'b1;
      ras_low_q <= 0;
      since_ref_q <= 0;
      ref_cnt_q <= 0;
    end else begin
      ras_q <= ras_n;
      ras_low_q <= ras_n ? 0 : ras_low_q + 1;
      since_ref_q <= ref_fall ? 0 : since_ref_q + 1;
      ref_cnt_q <= ref_fall ? ref_cnt_q + 1 : ref_cnt_q;
    end
  end
  // ------
  // checks
  // ------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_row_pulse_max: assert property (ras_low_q <= RAS_MAX)
    else $error("row strobe low too long");
  // slack covers an open page plus a read-write cycle
  a_refresh_gap: assert property (since_ref_q <= REFRESH_ROW_CYCLES + 160)
    else $error("refresh late");
  a_init_refresh_count: assert property ($rose(init_done) |-> ref_cnt_q >= INIT_REFRESHES)
    else $error("too few refreshes before ready");
  a_no_early_access: assert property (!init_done |-> cas_n && cs_n)
    else $error("access before init");
  a_col_after_row: assert property ($fell(cas_n) |-> !$past(ras_n) && !$past(ras_n, 2) && !cs_n)
    else $error("column strobe too soon");
  a_col_setup: assert property ($fell(cas_n) |-> $stable(muxed_address_lines) && $stable(din) && $stable(we_n))
    else $error("column setup broken");
  a_row_setup: assert property ($fell(ras_n) |-> $stable(muxed_address_lines) && $stable(cs_n))
    else $error("row setup broken");
  a_late_write: assert property ($fell(we_n) && !cas_n |-> (!$past(cas_n, 2) && !$past(ras_n, 4)) ##1 (!we_n && !cas_n))
    else $error("late write strobe timing");
  a_refresh_quiet: assert property (!ras_n && cs_n |-> cas_n && we_n)
    else $error("refresh touched column");
  a_resp_at_rise: assert property (rsp_valid |-> $rose(cas_n))
    else $error("response off column end");
  c_refresh: cover property (ref_fall);
  c_rmw: cover property ($fell(we_n) && !cas_n);
  c_page: cover property ($rose(cas_n) && !ras_n ##[1:3] $fell(cas_n));
endmodule
bind dram_host_ctrl dram_host_ctrl_monitor #(.REFRESH_ROW_CYCLES(REFRESH_ROW_CYCLES),
  .INIT_REFRESHES(INIT_REFRESHES)) i_mon (.sys_clk(sys_clk), .reset_n(reset_n), .init_done(init_done),
  .rsp_valid(rsp_valid), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cs_n(cs_n),
  .muxed_address_lines(muxed_address_lines), .din(din));
`default_nettype wire

/* File: testbench/dram_cell_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dram_cell_model (
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cs_n,
  input wire logic [5:0] muxed_address_lines,
  input wire logic din,
  output logic dout
);
  // ------
  // cell array and latches
  // ------
  logic mem [4096];
  logic [5:0] row;
  logic [11:0] a;
  logic sel;
  time t_ras;
  time t_cas;
  initial begin
    foreach (mem[i]) mem[i] = 1'b0;
    dout = 1'b0;
    row = 6'h00;
    a = 12'h000;
    sel = 1'b0;
    t_ras = 0;
    t_cas = 0;
  end
  // row half taken at row fall; refresh leaves dout alone
  always @(negedge ras_n) begin
    row = muxed_address_lines;
    t_ras = $time;
  end
  // column fall: old output lost at once, new bit after access time
  always @(negedge cas_n) begin
    a = {row, muxed_address_lines};
    sel = !cs_n;
    t_cas = $time;
    if (sel && !we_n) mem[a] = din;
    if (sel) dout = ~dout;
    #135;
    if (sel) dout = mem[a];
  end
  // late write strobe stores without touching dout
  // too soon after either strobe the output turns unknown, so a bad host shows up as a data miss
  always @(negedge we_n) begin
    if (sel && !cas_n) begin
      mem[a] = din;
      if ($time - t_cas < 80 || $time - t_ras < 145) dout = 1'bx;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/dram_host_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin bad_count++; $display("ERROR %s exp %b got %b", nm, ex, sn); end end
module dram_host_ctrl_tb;
  logic sys_clk, reset_n, req_valid, req_ready, req_write, req_rmw, req_wdata;
  logic rsp_valid, rsp_rdata, init_done, ras_n, cas_n, we_n, cs_n, din, dout;
  logic [11:0] req_addr;
  logic [5:0] mal;
  logic shadow [4096];
  logic [1:0] exp_q [$];
  logic [1:0] e;
  // last bit read back; reset clears the response register
  logic last_rd = 1'b0;
  int bad_count, n_compared, k, n;
  // short refresh interval keeps the run small
  dram_host_ctrl #(.REFRESH_ROW_CYCLES(200), .INIT_REFRESHES(8)) i_dram_host_ctrl (.sys_clk(sys_clk),
    .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_rmw(req_rmw),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cs_n(cs_n),
    .muxed_address_lines(mal), .din(din), .dout(dout));
  dram_cell_model i_dram_cell_model (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cs_n(cs_n),
    .muxed_address_lines(mal), .din(din), .dout(dout));
  // ------
  // clock, verdict, driver
  // ------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // valid stays up between calls so back-to-back requests can hit the open page
  task do_req(input logic w, input logic m, input logic [11:0] ad, input logic wd);
    int i;
    req_valid = 1'b1;
    req_write = w;
    req_rmw = m;
    req_addr = ad;
    req_wdata = wd;
    #1;
    for (i = 0; i < 400 && req_ready !== 1'b1; i++) begin
      @(negedge sys_clk);
      #1;
    end
    if (i == 400) begin
      bad_count++;
      end_of_test();
    end
    exp_q.push_back({m | !w, shadow[ad]});
    if (m | w) shadow[ad] = wd;
    @(negedge sys_clk);
  endtask
  // oldest note against each response
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1 && exp_q.size() == 0) `CHK("rsp_valid", 1'b0, rsp_valid)
    else if (rsp_valid === 1'b1) begin
      e = exp_q.pop_front();
      if (e[1]) begin
        `CHK("rsp_rdata", e[0], rsp_rdata)
        last_rd = e[0];
      end else `CHK("rsp_rdata_hold", last_rd, rsp_rdata)
    end
  end
  // ------
  // scenarios
  // ------
  initial begin
    foreach (shadow[i]) shadow[i] = 1'b0;
    {reset_n, req_valid, req_write, req_rmw, req_wdata} = 5'h00;
    req_addr = 12'h000;
    void'($urandom(32'h6AAF981A));
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    for (k = 0; k < 300 && init_done !== 1'b1; k++) @(negedge sys_clk);
    `CHK("init_done", 1'b1, init_done)
    if (init_done !== 1'b1) end_of_test();
    // corner cells, page hits, rmw winning over write
    do_req(1'b1, 1'b0, 12'hFFF, 1'b1);
    do_req(1'b0, 1'b1, 12'hFFF, 1'b0);
    do_req(1'b0, 1'b0, 12'hFFF, 1'b0);
    do_req(1'b1, 1'b1, 12'h000, 1'b1);
    do_req(1'b0, 1'b0, 12'h000, 1'b0);
    // two rows only, so page hits and refresh preemption both occur
    for (n = 0; n < 150; n++) begin
      k = $urandom_range(2, 0);
      do_req(k == 1, k == 2, {$urandom_range(1, 0) ? 6'h2A : 6'h15, 6'($urandom)}, 1'($urandom));
    end
    req_valid = 1'b0;
    for (k = 0; k < 100 && exp_q.size() != 0; k++) @(negedge sys_clk);
    `CHK("pending", 1'b0, exp_q.size() != 0)
    end_of_test();
  end
endmodule
`default_nettype wire
